// *** src/cvs_pkg.sv ***
// Register map, field layout and timing constants of the conversion sequencer
package cvs_pkg;

  // Command-byte addresses
  localparam logic [7:0] ADDR_COMMON_STATUS = 8'h02;
  localparam logic [7:0] ADDR_MAIN_CONFIG = 8'h03;
  localparam logic [7:0] ADDR_INTERVAL_SEL = 8'h04;
  localparam logic [7:0] ADDR_CHAN_ENABLE = 8'h05;
  localparam logic [7:0] ADDR_ONE_SHOT = 8'h0f;

  // Field positions
  localparam int STANDBY_BIT = 6;
  localparam int BUSY_BIT = 7;
  localparam int INTERVAL_LSB = 0;
  localparam int LOCAL_EN_BIT = 0;
  localparam int REMOTE1_EN_BIT = 1;
  localparam int REMOTE2_EN_BIT = 2;

  // Reset values
  localparam logic [7:0] MAIN_CONFIG_RST = 8'h00;
  localparam logic [7:0] INTERVAL_SEL_RST = 8'h02;
  localparam logic [7:0] CHAN_ENABLE_RST = 8'h1f;

  // Interval codes
  localparam logic [1:0] RATE_CONTINUOUS = 2'h0;
  localparam logic [1:0] RATE_364MS = 2'h1;
  localparam logic [1:0] RATE_1S = 2'h2;
  localparam logic [1:0] RATE_2500MS = 2'h3;

  // Timing: clock rate, millisecond prescale and interval lengths
  localparam int CLK_HZ = 10_000_000;
  localparam int MS_PER_S = 1000;
  localparam int MS_CYCLES = CLK_HZ / MS_PER_S;
  localparam logic [11:0] INTERVAL_364_MS = 12'd364;
  localparam logic [11:0] INTERVAL_1000_MS = 12'd1000;
  localparam logic [11:0] INTERVAL_2500_MS = 12'd2500;
  // One channel conversion; three channels give about 102 ms per sequence
  localparam logic [7:0] CONV_TIME_MS = 8'd34;

  localparam int NUM_CHAN = 3;
  localparam logic [1:0] CHAN_NONE = 2'h3;

endpackage : cvs_pkg

// *** src/cvs_tmr_if.sv ***
// Link between the sequencer and its millisecond interval timer
`timescale 1ns/100ps
`default_nettype none
interface cvs_tmr_if;
  logic restart;
  logic msTick;
  logic [11:0] msElapsed;
  modport seq (output restart, input msTick, input msElapsed);
  modport tmr (input restart, output msTick, output msElapsed);
endinterface : cvs_tmr_if
`default_nettype wire

// *** src/cvs_interval_timer.sv ***
// Millisecond prescaler and elapsed-time counter since the last restart
`timescale 1ns/100ps
`default_nettype none
module cvs_interval_timer
  import cvs_pkg::*;
#(
  parameter int MS_CYC = MS_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Timer link
  cvs_tmr_if.tmr tmr
);

  logic [23:0] preCnt_ff;
  logic [23:0] nxt_preCnt;
  logic [11:0] msElapsed_ff;
  logic [11:0] nxt_msElapsed;
  logic tick;

  assign tick = (preCnt_ff == 24'(MS_CYC - 1));
  assign tmr.msTick = tick;
  assign tmr.msElapsed = msElapsed_ff;

  always_comb begin
    nxt_preCnt = preCnt_ff + 24'h1;
    nxt_msElapsed = msElapsed_ff;
    if (tick) begin
      nxt_preCnt = 24'h0;
      // Saturate rather than wrap so a long wait never looks short
      if (msElapsed_ff != 12'hfff) begin
        nxt_msElapsed = msElapsed_ff + 12'h1;
      end
    end
    if (tmr.restart) begin
      nxt_preCnt = 24'h0;
      nxt_msElapsed = 12'h0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      preCnt_ff <= 24'h0;
      msElapsed_ff <= 12'h0;
    end else begin
      preCnt_ff <= nxt_preCnt;
      msElapsed_ff <= nxt_msElapsed;
    end
  end

endmodule : cvs_interval_timer
`default_nettype wire

// *** src/cvs_conversion_sequencer.sv ***
// Conversion scheduler: standby, one-shot, interval select, channel enables
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - A software standby bit resets to zero; one stops, zero converts.
// - In standby, a write to the one-shot address runs one sequence.
// - A two-bit interval field, reset to code 2, sets sequence spacing.
// - Code 0 is continuous, 1 is 0.364 s, 2 is 1 s and 3 is 2.5 s.
// - Enabled channels convert in turn, then the block idles out the rest.
// - A channel whose enable bit is zero is skipped in every sequence.
// - Skipped channels shorten continuous mode but not timed intervals.
// - Enable bit 2 is remote 2, bit 1 remote 1, bit 0 the local channel.
// - Reserved bits of the three control registers always read zero.
// - The value written to the one-shot address is ignored.
// - A busy flag in the common status register shows a conversion.
module cvs_conversion_sequencer
  import cvs_pkg::*;
#(
  parameter int MS_CYC = MS_CYCLES,
  parameter logic [7:0] CONV_MS = CONV_TIME_MS
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Register port from the management-bus slave
  input wire logic [7:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  // Conversion control to the front end
  output logic convBusy,
  output logic [2:0] convChanOh
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CONV = 3'b010,
    ST_WAIT = 3'b100
  } cvs_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  logic softwareStandby_ff;
  logic nxt_softwareStandby;
  logic [1:0] intervalSelect_ff;
  logic [1:0] nxt_intervalSelect;
  logic [2:0] chanEnable_ff;
  logic [2:0] nxt_chanEnable;
  logic [7:0] rdData_ff;
  logic [7:0] nxt_rdData;
  logic oneShotWr;

  // Only the write event matters, never the data
  assign oneShotWr = regWrEn && (regAddr == ADDR_ONE_SHOT);

  always_comb begin
    nxt_softwareStandby = softwareStandby_ff;
    nxt_intervalSelect = intervalSelect_ff;
    nxt_chanEnable = chanEnable_ff;
    if (regWrEn) begin
      case (regAddr)
        ADDR_MAIN_CONFIG: begin
          nxt_softwareStandby = regWrData[STANDBY_BIT];
        end
        ADDR_INTERVAL_SEL: begin
          nxt_intervalSelect = regWrData[INTERVAL_LSB +: 2];
        end
        ADDR_CHAN_ENABLE: begin
          nxt_chanEnable = regWrData[2:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Unstored bits stay zero on read
  always_comb begin
    nxt_rdData = 8'h00;
    case (regAddr)
      ADDR_COMMON_STATUS: begin
        nxt_rdData[BUSY_BIT] = convBusy;
      end
      ADDR_MAIN_CONFIG: begin
        nxt_rdData[STANDBY_BIT] = softwareStandby_ff;
      end
      ADDR_INTERVAL_SEL: begin
        nxt_rdData[INTERVAL_LSB +: 2] = intervalSelect_ff;
      end
      ADDR_CHAN_ENABLE: begin
        nxt_rdData[LOCAL_EN_BIT] = chanEnable_ff[0];
        nxt_rdData[REMOTE1_EN_BIT] = chanEnable_ff[1];
        nxt_rdData[REMOTE2_EN_BIT] = chanEnable_ff[2];
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      softwareStandby_ff <= MAIN_CONFIG_RST[STANDBY_BIT];
      intervalSelect_ff <= INTERVAL_SEL_RST[1:0];
      chanEnable_ff <= CHAN_ENABLE_RST[2:0];
      rdData_ff <= 8'h00;
    end else begin
      softwareStandby_ff <= nxt_softwareStandby;
      intervalSelect_ff <= nxt_intervalSelect;
      chanEnable_ff <= nxt_chanEnable;
      rdData_ff <= nxt_rdData;
    end
  end

  assign regRdData = rdData_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Interval timer

  cvs_tmr_if tmrLink ();

  cvs_interval_timer #(
    .MS_CYC(MS_CYC)
  ) u_timer (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .tmr(tmrLink.tmr)
  );

  logic [11:0] intervalMs;

  always_comb begin
    case (intervalSelect_ff)
      RATE_364MS: intervalMs = INTERVAL_364_MS;
      RATE_1S: intervalMs = INTERVAL_1000_MS;
      RATE_2500MS: intervalMs = INTERVAL_2500_MS;
      default: intervalMs = 12'h0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  // First enabled channel above index 'from' (use CHAN_NONE to start)
  function automatic logic [1:0] nextChan(input logic [2:0] en,
                                          input logic [1:0] from);
    logic [1:0] found;
    found = CHAN_NONE;
    for (int i = NUM_CHAN - 1; i >= 0; i--) begin
      if (en[i] && ((from == CHAN_NONE) || (i > int'(from)))) begin
        found = 2'(i);
      end
    end
    return found;
  endfunction : nextChan

  cvs_state_t state_ff;
  cvs_state_t nxt_state;
  logic [1:0] chan_ff;
  logic [1:0] nxt_chan;
  logic [7:0] convMs_ff;
  logic [7:0] nxt_convMs;
  logic startSeq;
  logic [1:0] firstChan;
  logic [1:0] followChan;

  // Standby clear runs free; a one-shot write only counts in standby
  assign startSeq = !softwareStandby_ff || oneShotWr;
  assign firstChan = nextChan(chanEnable_ff, CHAN_NONE);
  assign followChan = nextChan(chanEnable_ff, chan_ff);

  always_comb begin
    nxt_state = state_ff;
    nxt_chan = chan_ff;
    nxt_convMs = convMs_ff;
    tmrLink.restart = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (startSeq) begin
          tmrLink.restart = 1'b1;
          nxt_convMs = 8'h0;
          nxt_chan = firstChan;
          if (firstChan != CHAN_NONE) begin
            nxt_state = ST_CONV;
          end else if (!softwareStandby_ff &&
                       intervalSelect_ff != RATE_CONTINUOUS) begin
            nxt_state = ST_WAIT;
          end
        end
      end
      ST_CONV: begin
        if (tmrLink.msTick) begin
          nxt_convMs = convMs_ff + 8'h1;
          if (convMs_ff == CONV_MS - 8'h1) begin
            nxt_convMs = 8'h0;
            nxt_chan = followChan;
            if (followChan == CHAN_NONE) begin
              // Continuous mode and one-shot end at the last channel
              if (softwareStandby_ff ||
                  intervalSelect_ff == RATE_CONTINUOUS) begin
                nxt_state = ST_IDLE;
              end else begin
                nxt_state = ST_WAIT;
              end
            end
          end
        end
      end
      ST_WAIT: begin
        // Timed from sequence start, so skipped channels add idle time
        if (softwareStandby_ff || tmrLink.msElapsed >= intervalMs) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state_ff <= ST_IDLE;
      chan_ff <= CHAN_NONE;
      convMs_ff <= 8'h0;
    end else begin
      state_ff <= nxt_state;
      chan_ff <= nxt_chan;
      convMs_ff <= nxt_convMs;
    end
  end

  assign convBusy = (state_ff == ST_CONV);

  always_comb begin
    convChanOh = 3'h0;
    if (state_ff == ST_CONV && chan_ff != CHAN_NONE) begin
      convChanOh[chan_ff] = 1'b1;
    end
  end

endmodule : cvs_conversion_sequencer
`default_nettype wire

// *** dv/cvs_seq_checker.sv ***
// Port checker for the conversion sequencer
`timescale 1ns/100ps
`default_nettype none
module cvs_seq_checker
  import cvs_pkg::*;
#(
  parameter int MS_CYC = MS_CYCLES,
  parameter logic [7:0] CONV_MS = CONV_TIME_MS
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Register port and conversion control
  input wire logic [7:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic [7:0] regRdData,
  input wire logic convBusy,
  input wire logic [2:0] convChanOh
);
  logic [2:0] prevChan_ff;
  logic [2:0] nxt_prevChan;
  // Wide enough for a full channel time at the default prescale
  logic [31:0] runLen_ff;
  logic [31:0] nxt_runLen;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////
  // Cycles the present channel code has been held
  always_comb begin
    nxt_prevChan = convChanOh;
    nxt_runLen = (convChanOh == prevChan_ff) ? runLen_ff + 32'h1 : 32'h1;
  end
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      prevChan_ff <= 3'h0;
      runLen_ff <= 32'h0;
    end else begin
      prevChan_ff <= nxt_prevChan;
      runLen_ff <= nxt_runLen;
    end
  end
  ////////////////////////////////////////
  AST_FIRST: assert property ($rose(nrst) |=> convBusy)
    else $error("no sequence after reset");
  AST_ONEHOT: assert property (convBusy |-> $onehot(convChanOh))
    else $error("busy without one channel");
  AST_IDLE: assert property (!convBusy |-> convChanOh == 3'h0)
    else $error("channel while idle");
  AST_ORDER: assert property (prevChan_ff != 3'h0 && convChanOh != 3'h0
    && convChanOh != prevChan_ff |-> convChanOh > prevChan_ff)
    else $error("channel order");
  AST_TIME: assert property (prevChan_ff != 3'h0
    && convChanOh != prevChan_ff |-> runLen_ff == 32'(int'(CONV_MS) * MS_CYC))
    else $error("channel time");
  AST_RSVD: assert property (regAddr == ADDR_MAIN_CONFIG |=>
    (regRdData & 8'hbf) == 8'h00) else $error("config reserved bits");
  AST_BUSY: assert property (regAddr == ADDR_COMMON_STATUS |=>
    regRdData[BUSY_BIT] == $past(convBusy)) else $error("busy flag");
  AST_SHOT: assert property (regAddr == ADDR_ONE_SHOT |=>
    regRdData == 8'h00) else $error("one-shot value kept");
  AST_SOFTWARE_STANDBY: assert property (regWrEn && regAddr == ADDR_MAIN_CONFIG
    ##1 (!regWrEn && regAddr == ADDR_MAIN_CONFIG) |=>
    regRdData == ($past(regWrData, 2) & 8'h40)) else $error("standby bit");
endmodule : cvs_seq_checker
bind cvs_conversion_sequencer cvs_seq_checker #(.MS_CYC(MS_CYC),
  .CONV_MS(CONV_MS)) u_chk (.clk_sys(clk_sys), .nrst(nrst),
  .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
  .regRdData(regRdData), .convBusy(convBusy), .convChanOh(convChanOh));
`default_nettype wire

// *** dv/cvs_host_model.sv ***
// Management-bus host stand-in: single-byte writes and reads
`timescale 1ns/100ps
`default_nettype none
module cvs_host_model (
  // Clock
  input wire logic clk_sys,
  // Register port
  output logic [7:0] regAddr,
  output logic regWrEn,
  output logic [7:0] regWrData,
  input wire logic [7:0] regRdData
);
  initial begin
    regAddr = 8'h00;
    regWrEn = 1'b0;
    regWrData = 8'h00;
  end
  // Data is inverted after the strobe so nothing leans on a stale value
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= v;
    regWrEn <= 1'b1;
    @(posedge clk_sys);
    regWrEn <= 1'b0;
    regWrData <= ~v;
  endtask : wr
  // Read data is registered, so it is taken a cycle after the address
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    regAddr <= a;
    @(posedge clk_sys);
    @(negedge clk_sys);
    v = regRdData;
  endtask : rd
endmodule : cvs_host_model
`default_nettype wire

// *** dv/cvs_conversion_sequencer_tb.sv ***
// Random and corner-case bench for the conversion sequencer
`timescale 1ns/100ps
`default_nettype none
module cvs_conversion_sequencer_tb
  import cvs_pkg::*;
;
  localparam int MSC = 10;
  localparam logic [7:0] CMS = 8'h02;
  localparam int CH = int'(CMS) * MSC;
  logic clk_sys;
  logic nrst;
  logic [7:0] regAddr;
  logic regWrEn;
  logic [7:0] regWrData;
  logic [7:0] regRdData;
  logic convBusy;
  logic [2:0] convChanOh;
  logic [7:0] d;
  logic [7:0] r;
  int num_errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  cvs_conversion_sequencer #(.MS_CYC(MSC), .CONV_MS(CMS)) DUT (
    .clk_sys(clk_sys), .nrst(nrst), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdData(regRdData), .convBusy(convBusy),
    .convChanOh(convChanOh));
  cvs_host_model HOST (.clk_sys(clk_sys), .regAddr(regAddr),
    .regWrEn(regWrEn), .regWrData(regWrData), .regRdData(regRdData));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) cyc <= cyc + 1;
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  task automatic stop_test();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test
  // Read-back of a written byte: only the stored fields survive
  function automatic logic [7:0] expRd(input logic [7:0] a,
                                       input logic [7:0] v);
    case (a)
      ADDR_MAIN_CONFIG: return v & 8'h40;
      ADDR_INTERVAL_SEL: return v & 8'h03;
      ADDR_CHAN_ENABLE: return v & 8'h07;
      default: return 8'h00;
    endcase
  endfunction : expRd
  // Reset values, read while the first sequence after release runs
  task automatic rstVals();
    HOST.rd(ADDR_COMMON_STATUS, d);
    chk(d, 8'h80);
    HOST.rd(ADDR_MAIN_CONFIG, d);
    chk(d, expRd(ADDR_MAIN_CONFIG, MAIN_CONFIG_RST));
    HOST.rd(ADDR_INTERVAL_SEL, d);
    chk(d, expRd(ADDR_INTERVAL_SEL, INTERVAL_SEL_RST));
    HOST.rd(ADDR_CHAN_ENABLE, d);
    chk(d, expRd(ADDR_CHAN_ENABLE, CHAN_ENABLE_RST));
    HOST.rd(ADDR_ONE_SHOT, d);
    chk(d, 8'h00);
  endtask : rstVals
  task automatic waitb(input logic v, input int lim);
    int n;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (convBusy !== v && n < lim);
    chk(convBusy, v);
  endtask : waitb
  // Follows one sequence from its first busy cycle
  task automatic seq(input logic [2:0] en);
    waitb(1'b1, 200);
    for (int i = 0; i < 3; i++) begin
      if (en[i]) begin
        repeat (CH) begin
          chk(convChanOh, 3'h1 << i);
          @(negedge clk_sys);
        end
      end
    end
    chk(convBusy, 1'b0);
  endtask : seq
  task automatic idle(input int n);
    logic q;
    q = 1'b1;
    repeat (n) begin
      @(negedge clk_sys);
      if (convBusy !== 1'b0) q = 1'b0;
    end
    chk(q, 1'b1);
  endtask : idle
  // Restarting from standby gives a known start for the period measurement
  task automatic period(input logic [1:0] c, input logic [2:0] en, int e);
    int t0;
    HOST.wr(ADDR_MAIN_CONFIG, 8'h40);
    waitb(1'b0, 100);
    HOST.wr(ADDR_INTERVAL_SEL, {6'h0, c});
    HOST.wr(ADDR_CHAN_ENABLE, {5'h0, en});
    HOST.wr(ADDR_MAIN_CONFIG, 8'h00);
    waitb(1'b1, 10);
    t0 = cyc;
    waitb(1'b0, 100);
    waitb(1'b1, 30000);
    chk(32'(cyc - t0 >= e - 3 && cyc - t0 <= e + 3), 32'h1);
  endtask : period
  ////////////////////////////////////////
  initial begin
    #(100 * 80000);
    num_errors++;
    stop_test();
  end
  initial begin
    nrst = 1'b0;
    void'($urandom(33318));
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    rstVals();
    repeat (4) begin
      r = 8'($urandom);
      HOST.wr(ADDR_INTERVAL_SEL, r);
      HOST.rd(ADDR_INTERVAL_SEL, d);
      chk(d, expRd(ADDR_INTERVAL_SEL, r));
      r = 8'($urandom);
      HOST.wr(ADDR_CHAN_ENABLE, r);
      HOST.rd(ADDR_CHAN_ENABLE, d);
      chk(d, expRd(ADDR_CHAN_ENABLE, r));
    end
    // Continuous rate first, so a missed standby would show within a sequence
    HOST.wr(ADDR_INTERVAL_SEL, 8'h00);
    HOST.wr(ADDR_CHAN_ENABLE, 8'h07);
    HOST.wr(ADDR_MAIN_CONFIG, 8'hff);
    HOST.rd(ADDR_MAIN_CONFIG, d);
    chk(d, 8'h40);
    waitb(1'b0, 100);
    idle(200);
    HOST.rd(ADDR_COMMON_STATUS, d);
    chk(d, 8'h00);
    for (int e = 1; e < 8; e++) begin
      HOST.wr(ADDR_CHAN_ENABLE, 8'(e));
      HOST.wr(ADDR_ONE_SHOT, 8'($urandom));
      seq(3'(e));
      idle(100);
    end
    // Second reset while idle, with standby set and the interval field off its default
    @(posedge clk_sys);
    nrst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    rstVals();
    period(RATE_CONTINUOUS, 3'h7, 3 * CH + 1);
    period(RATE_CONTINUOUS, 3'h1, CH + 1);
    period(RATE_364MS, 3'h1, 364 * MSC);
    period(RATE_364MS, 3'h7, 364 * MSC);
    period(RATE_1S, 3'h7, 1000 * MSC);
    period(RATE_2500MS, 3'h5, 2500 * MSC);
    stop_test();
  end
endmodule : cvs_conversion_sequencer_tb
`default_nettype wire
